// ===== scp_pkg.sv
/*
   constants and types shared by the sync/clock/power register bank:
   register indices, field positions, reset values, swing formula terms.
   assumes word-aligned AHB-Lite access, byte address = 4 x index.
*/
package scp_pkg;
   // register indices; byte address is four times the index
   localparam logic [9:0] IDX_SYNC_REF    = 10'h084;
   localparam logic [9:0] IDX_STARTUP     = 10'h085;
   localparam logic [9:0] IDX_SWING       = 10'h08D;
   localparam logic [9:0] IDX_DRIVER      = 10'h08F;
   localparam logic [9:0] IDX_CONV_PD     = 10'h090;
   localparam logic [9:0] IDX_ACLK        = 10'h091;
   localparam logic [9:0] IDX_SWING_STAT  = 10'h092;

   // field positions
   localparam int SYNC_COUPLING_BIT = 6;
   localparam int SYNC_PD_BIT       = 0;
   localparam int START_A_LSB       = 4;
   localparam int START_A_MSB       = 6;
   localparam int START_B_BIT       = 1;
   localparam int START_C_BIT       = 0;
   localparam int SWING_MSB         = 4;
   localparam int DRIVER_OFF_BIT    = 0;
   localparam int ACLK_OFF_BIT      = 0;
   localparam int NUM_CONVERTERS    = 2;
   localparam int STAT_INVERT_BIT   = 0;
   localparam int STAT_BADCODE_BIT  = 1;

   // values after reset
   localparam logic [7:0] RST_SYNC_REF = 8'h00;
   localparam logic [2:0] RST_START_A  = 3'h1;
   localparam logic       RST_START_B  = 1'h1;
   localparam logic       RST_START_C  = 1'h0;
   localparam logic [4:0] RST_SWING    = 5'h00;
   localparam logic       RST_DRIVER   = 1'h0;
   localparam logic [1:0] RST_CONV_PD  = 2'h3;
   localparam logic [7:0] RST_ACLK     = 8'h01;

   // swing formula terms; base, step and offset in mV, top and last values are codes
   localparam int SWING_BASE_MV    = 993;
   localparam int SWING_STEP_MV    = 77;
   localparam int SWING_NEG_TOP    = 20;
   localparam int SWING_NEG_OFS_MV = 1000;
   localparam logic [4:0] SWING_LAST_POS = 5'h09;
   localparam logic [4:0] SWING_LAST_NEG = 5'h13;

   localparam logic [2:0] HSIZE_WORD = 3'h2;

   typedef enum logic [1:0] {
      BUS_IDLE,
      BUS_WR_DATA,
      BUS_RD_WAIT,
      BUS_RD_DATA
   } scp_bus_state_t;
endpackage : scp_pkg

// ===== scp_regs.sv
/*
   sync reference, start-up, clock driver and power-down register bank
   behind an AHB-Lite slave port. holds the control bits that steer the
   analog circuits and a status word for the decoded clock swing.
   assumes a single AHB-Lite master on CLK_I, word transfers only.
*/
// Implementation choice: register access over AHB-Lite.
// Summary of operation
// - bit 6 picks sync input coupling, AC/DC
// - bit 0 powers down sync receiver
// - codes 0-9: swing 993 minus 77 per step
// - codes 10-19: negative swing, inverted clock
// - driver control bit 0 powers driver down
// - one power-down bit per converter, reset set
// - analog clock receiver off after reset
`timescale 1ns/10ps
module scp_regs
   import scp_pkg::*;
(
   // clock and reset
   input  wire logic        CLK_I,
   input  wire logic        SYS_RST_I,
   // AHB-Lite slave
   input  wire logic        HSEL_I,
   input  wire logic [31:0] HADDR_I,
   input  wire logic [1:0]  HTRANS_I,
   input  wire logic        HWRITE_I,
   input  wire logic [2:0]  HSIZE_I,
   input  wire logic [31:0] HWDATA_I,
   input  wire logic        HREADY_I,
   output logic      [31:0] HRDATA_O,
   output logic             HREADYOUT_O,
   output logic             HRESP_O,
   // sync reference receiver
   output logic             SYNC_REF_COUPLING_SEL_O,
   output logic             SYNC_REF_RX_POWERDOWN_O,
   // start-up programming window
   output logic      [2:0]  STARTUP_CTRL_A_O,
   output logic             STARTUP_CTRL_B_O,
   output logic             STARTUP_CTRL_C_O,
   // observation clock output driver
   output logic      [4:0]  ADC_CLOCK_SWING_CODE_O,
   output logic      [11:0] ADC_CLOCK_SWING_MV_O,
   output logic             ADC_CLOCK_INVERT_O,
   output logic             ADC_CLOCK_DRIVER_OFF_O,
   // converters and analog clock
   output logic             CONVERTER0_POWERDOWN_O,
   output logic             CONVERTER1_POWERDOWN_O,
   output logic             ANALOG_CLOCK_RX_OFF_O
);
   scp_bus_state_t state;
   logic [9:0]     addr_idx;
   logic           addr_ok;
   logic           hready;
   logic [31:0]    hrdata;
   logic           accept;
   logic           word_ok;
   logic           wr_fire;

   logic [7:0]     sync_ref_control;
   logic [2:0]     startup_a;
   logic           startup_b;
   logic           startup_c;
   logic [4:0]     swing_code;
   logic           driver_off;
   logic [NUM_CONVERTERS-1:0] conv_pd;
   logic [7:0]     analog_clock_rx_control;

   scp_swing_if    swing_bus ();

   // decode of the captured address against one register index
   function automatic logic hit(input logic [9:0] idx, input logic [9:0] cur, input logic ok);
      hit = ok && (cur == idx);
   endfunction : hit

   // read view of the register file; reserved bits read as zero, except sync reference and analog clock, which return all 8 stored bits
   function automatic logic [7:0] rd_value(input logic [9:0] cur, input logic ok);
      rd_value = 8'h00;
      if (hit(IDX_SYNC_REF, cur, ok)) begin
         rd_value = sync_ref_control;
      end else if (hit(IDX_STARTUP, cur, ok)) begin
         rd_value[START_A_MSB:START_A_LSB] = startup_a;
         rd_value[START_B_BIT]             = startup_b;
         rd_value[START_C_BIT]             = startup_c;
      end else if (hit(IDX_SWING, cur, ok)) begin
         rd_value[SWING_MSB:0] = swing_code;
      end else if (hit(IDX_DRIVER, cur, ok)) begin
         rd_value[DRIVER_OFF_BIT] = driver_off;
      end else if (hit(IDX_CONV_PD, cur, ok)) begin
         rd_value[NUM_CONVERTERS-1:0] = conv_pd;
      end else if (hit(IDX_ACLK, cur, ok)) begin
         rd_value = analog_clock_rx_control;
      end else if (hit(IDX_SWING_STAT, cur, ok)) begin
         rd_value[STAT_INVERT_BIT]  = swing_bus.invert;
         rd_value[STAT_BADCODE_BIT] = !swing_bus.code_valid;
      end
   endfunction : rd_value

   assign accept  = HSEL_I && HTRANS_I[1] && HREADY_I;
   assign word_ok = (HSIZE_I == HSIZE_WORD);
   assign wr_fire = (state == BUS_WR_DATA);

   // bus phase tracking; reads take one wait state so read data come
   // from a register and already see a write that ended just before
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         state <= BUS_IDLE;
         hready <= 1'b1;
      end else begin
         case (state)
            BUS_RD_WAIT: begin
               state  <= BUS_RD_DATA;
               hready <= 1'b1;
            end
            BUS_IDLE, BUS_WR_DATA, BUS_RD_DATA: begin
               if (accept && !HWRITE_I) begin
                  state  <= BUS_RD_WAIT;
                  hready <= 1'b0;
               end else if (accept && word_ok) begin
                  state <= BUS_WR_DATA;
               end else begin
                  state <= BUS_IDLE;
               end
            end
            default: begin
               state  <= BUS_IDLE;
               hready <= 1'b1;
            end
         endcase
      end
   end

   // address phase capture; partial-word and upper addresses decode to nothing
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         addr_idx <= 10'h000;
         addr_ok  <= 1'b0;
      end else if (accept) begin
         addr_idx <= HADDR_I[11:2];
         addr_ok  <= (HADDR_I[31:12] == 20'h00000) && (HADDR_I[1:0] == 2'h0) && word_ok;
      end
   end

   // read data register
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         hrdata <= 32'h00000000;
      end else if (state == BUS_RD_WAIT) begin
         hrdata <= {24'h000000, rd_value(addr_idx, addr_ok)};
      end
   end

   // sync reference control: every bit stored, reserved ones too
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         sync_ref_control <= RST_SYNC_REF;
      end else if (wr_fire && hit(IDX_SYNC_REF, addr_idx, addr_ok)) begin
         sync_ref_control <= HWDATA_I[7:0];
      end
   end

   // start-up programming fields; sequencing is left to software
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         startup_a <= RST_START_A;
         startup_b <= RST_START_B;
         startup_c <= RST_START_C;
      end else if (wr_fire && hit(IDX_STARTUP, addr_idx, addr_ok)) begin
         startup_a <= HWDATA_I[START_A_MSB:START_A_LSB];
         startup_b <= HWDATA_I[START_B_BIT];
         startup_c <= HWDATA_I[START_C_BIT];
      end
   end

   // clock driver swing code and power-down
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         swing_code <= RST_SWING;
      end else if (wr_fire && hit(IDX_SWING, addr_idx, addr_ok)) begin
         swing_code <= HWDATA_I[SWING_MSB:0];
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         driver_off <= RST_DRIVER;
      end else if (wr_fire && hit(IDX_DRIVER, addr_idx, addr_ok)) begin
         driver_off <= HWDATA_I[DRIVER_OFF_BIT];
      end
   end

   // one power-down bit per converter
   for (genvar i = 0; i < NUM_CONVERTERS; i++) begin : g_conv
      always_ff @(posedge CLK_I) begin
         if (SYS_RST_I) begin
            conv_pd[i] <= RST_CONV_PD[i];
         end else if (wr_fire && hit(IDX_CONV_PD, addr_idx, addr_ok)) begin
            conv_pd[i] <= HWDATA_I[i];
         end
      end
   end

   // analog clock receiver; starts powered down
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         analog_clock_rx_control <= RST_ACLK;
      end else if (wr_fire && hit(IDX_ACLK, addr_idx, addr_ok)) begin
         analog_clock_rx_control <= HWDATA_I[7:0];
      end
   end

   assign swing_bus.code = swing_code;

   scp_swing_dec u_swing_dec (
      .CLK_I     (CLK_I),
      .SYS_RST_I (SYS_RST_I),
      .sw        (swing_bus)
   );

   // the decoded level lags the code by one cycle
   assign HRDATA_O                = hrdata;
   assign HREADYOUT_O             = hready;
   assign HRESP_O                 = 1'b0;
   assign SYNC_REF_COUPLING_SEL_O = sync_ref_control[SYNC_COUPLING_BIT];
   assign SYNC_REF_RX_POWERDOWN_O = sync_ref_control[SYNC_PD_BIT];
   assign STARTUP_CTRL_A_O        = startup_a;
   assign STARTUP_CTRL_B_O        = startup_b;
   assign STARTUP_CTRL_C_O        = startup_c;
   assign ADC_CLOCK_SWING_CODE_O  = swing_code;
   assign ADC_CLOCK_SWING_MV_O    = swing_bus.swing_mv;
   assign ADC_CLOCK_INVERT_O      = swing_bus.invert;
   assign ADC_CLOCK_DRIVER_OFF_O  = driver_off;
   assign CONVERTER0_POWERDOWN_O  = conv_pd[0];
   assign CONVERTER1_POWERDOWN_O  = conv_pd[1];
   assign ANALOG_CLOCK_RX_OFF_O   = analog_clock_rx_control[ACLK_OFF_BIT];

   AST_SYNC_COUPLING: assert property (
      @(posedge CLK_I) disable iff (SYS_RST_I)
      (wr_fire && hit(IDX_SYNC_REF, addr_idx, addr_ok)) |=>
         (SYNC_REF_COUPLING_SEL_O == $past(HWDATA_I[SYNC_COUPLING_BIT]))
   ) else $error("sync coupling bit did not follow write");

   AST_SYNC_PD: assert property (
      @(posedge CLK_I) disable iff (SYS_RST_I)
      (wr_fire && hit(IDX_SYNC_REF, addr_idx, addr_ok)) |=>
         (SYNC_REF_RX_POWERDOWN_O == $past(HWDATA_I[SYNC_PD_BIT]))
   ) else $error("sync power-down bit did not follow write");

   AST_SYNC_RESET: assert property (
      @(posedge CLK_I)
      SYS_RST_I |=> (!SYNC_REF_COUPLING_SEL_O && !SYNC_REF_RX_POWERDOWN_O)
   ) else $error("sync control not cleared by reset");

   AST_DRIVER_OFF: assert property (
      @(posedge CLK_I) disable iff (SYS_RST_I)
      (wr_fire && hit(IDX_DRIVER, addr_idx, addr_ok)) |=>
         (ADC_CLOCK_DRIVER_OFF_O == $past(HWDATA_I[DRIVER_OFF_BIT]))
   ) else $error("driver power-down bit did not follow write");

   AST_CONV_PD_RESET: assert property (
      @(posedge CLK_I)
      SYS_RST_I |=> (CONVERTER0_POWERDOWN_O && CONVERTER1_POWERDOWN_O && !ADC_CLOCK_DRIVER_OFF_O)
   ) else $error("converters not powered down after reset");

   AST_CONV_PD_HOLD: assert property (
      @(posedge CLK_I) disable iff (SYS_RST_I)
      !(wr_fire && hit(IDX_CONV_PD, addr_idx, addr_ok)) |=>
         ({CONVERTER1_POWERDOWN_O, CONVERTER0_POWERDOWN_O} == $past(conv_pd))
   ) else $error("converter power-down changed without a write");

   AST_ACLK_RESET: assert property (
      @(posedge CLK_I)
      SYS_RST_I ##1 (!SYS_RST_I && !wr_fire)[*2] |-> ANALOG_CLOCK_RX_OFF_O
   ) else $error("analog clock receiver not off after reset");

   AST_READ_TIMING: assert property (
      @(posedge CLK_I) disable iff (SYS_RST_I)
      (accept && !HWRITE_I) |=> !HREADYOUT_O ##1 HREADYOUT_O
   ) else $error("read did not complete with one wait state");

   AST_WRITE_TIMING: assert property (
      @(posedge CLK_I) disable iff (SYS_RST_I)
      (accept && HWRITE_I) |=> HREADYOUT_O
   ) else $error("write data phase was stalled");

   // hold checks catch a stray write strobe or a loose index decode
   AST_SYNC_HOLD: assert property (
      @(posedge CLK_I) disable iff (SYS_RST_I)
      !(wr_fire && hit(IDX_SYNC_REF, addr_idx, addr_ok)) |=>
         $stable({SYNC_REF_COUPLING_SEL_O, SYNC_REF_RX_POWERDOWN_O})
   ) else $error("sync control changed without a write");

   AST_STARTUP_RESET: assert property (
      @(posedge CLK_I)
      SYS_RST_I |=> (STARTUP_CTRL_A_O == RST_START_A && STARTUP_CTRL_B_O == RST_START_B &&
                     STARTUP_CTRL_C_O == RST_START_C)
   ) else $error("start-up fields not restored by reset");

   AST_STARTUP_WRITE: assert property (
      @(posedge CLK_I) disable iff (SYS_RST_I)
      (wr_fire && hit(IDX_STARTUP, addr_idx, addr_ok)) |=>
         (STARTUP_CTRL_A_O == $past(HWDATA_I[START_A_MSB:START_A_LSB]) &&
          STARTUP_CTRL_B_O == $past(HWDATA_I[START_B_BIT]) &&
          STARTUP_CTRL_C_O == $past(HWDATA_I[START_C_BIT]))
   ) else $error("start-up fields did not follow write");

   AST_STARTUP_HOLD: assert property (
      @(posedge CLK_I) disable iff (SYS_RST_I)
      !(wr_fire && hit(IDX_STARTUP, addr_idx, addr_ok)) |=>
         $stable({STARTUP_CTRL_A_O, STARTUP_CTRL_B_O, STARTUP_CTRL_C_O})
   ) else $error("start-up fields changed without a write");

   AST_SWING_CODE_WRITE: assert property (
      @(posedge CLK_I) disable iff (SYS_RST_I)
      (wr_fire && hit(IDX_SWING, addr_idx, addr_ok)) |=>
         (ADC_CLOCK_SWING_CODE_O == $past(HWDATA_I[SWING_MSB:0]))
   ) else $error("swing code did not follow write");

   AST_SWING_RESET: assert property (
      @(posedge CLK_I)
      SYS_RST_I |=> (ADC_CLOCK_SWING_CODE_O == RST_SWING && !ADC_CLOCK_INVERT_O &&
                     ADC_CLOCK_SWING_MV_O == 12'(SWING_BASE_MV))
   ) else $error("swing not restored by reset");

   AST_DRIVER_HOLD: assert property (
      @(posedge CLK_I) disable iff (SYS_RST_I)
      !(wr_fire && hit(IDX_DRIVER, addr_idx, addr_ok)) |=> $stable(ADC_CLOCK_DRIVER_OFF_O)
   ) else $error("driver power-down changed without a write");

   AST_CONV_PD_WRITE: assert property (
      @(posedge CLK_I) disable iff (SYS_RST_I)
      (wr_fire && hit(IDX_CONV_PD, addr_idx, addr_ok)) |=>
         ({CONVERTER1_POWERDOWN_O, CONVERTER0_POWERDOWN_O} == $past(HWDATA_I[NUM_CONVERTERS-1:0]))
   ) else $error("converter power-down did not follow write");

   AST_ACLK_WRITE: assert property (
      @(posedge CLK_I) disable iff (SYS_RST_I)
      (wr_fire && hit(IDX_ACLK, addr_idx, addr_ok)) |=>
         (ANALOG_CLOCK_RX_OFF_O == $past(HWDATA_I[ACLK_OFF_BIT]))
   ) else $error("analog clock receiver bit did not follow write");

   AST_ACLK_HOLD: assert property (
      @(posedge CLK_I) disable iff (SYS_RST_I)
      !(wr_fire && hit(IDX_ACLK, addr_idx, addr_ok)) |=> $stable(ANALOG_CLOCK_RX_OFF_O)
   ) else $error("analog clock receiver bit changed without a write");
endmodule : scp_regs

// ===== scp_regs_tb.sv
/*
   self-checking testbench for the sync/clock/power register bank:
   an AHB-Lite master task pair, register and pin checks, reset checks.
   assumes one master, hready looped back from the slave, 50 MHz clock.
*/
`timescale 1ns/10ps
module scp_regs_tb
   import scp_pkg::*;
();
   logic        clk;
   logic        rst;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hready;
   logic        hresp;
   logic        coupling;
   logic        sync_pd;
   logic [2:0]  st_a;
   logic        st_b;
   logic        st_c;
   logic [4:0]  sw_code;
   logic [11:0] sw_mv;
   logic        sw_inv;
   logic        drv_off;
   logic        conv0_pd;
   logic        conv1_pd;
   logic        aclk_off;
   int          err_total;
   int          checks_done;
   int          exp_mv;
   logic [31:0] rd_val;

   scp_regs dut_u (
      .CLK_I(clk), .SYS_RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
      .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready),
      .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
      .SYNC_REF_COUPLING_SEL_O(coupling), .SYNC_REF_RX_POWERDOWN_O(sync_pd),
      .STARTUP_CTRL_A_O(st_a), .STARTUP_CTRL_B_O(st_b), .STARTUP_CTRL_C_O(st_c),
      .ADC_CLOCK_SWING_CODE_O(sw_code), .ADC_CLOCK_SWING_MV_O(sw_mv), .ADC_CLOCK_INVERT_O(sw_inv),
      .ADC_CLOCK_DRIVER_OFF_O(drv_off), .CONVERTER0_POWERDOWN_O(conv0_pd),
      .CONVERTER1_POWERDOWN_O(conv1_pd), .ANALOG_CLOCK_RX_OFF_O(aclk_off)
   );

   always #10 clk = ~clk;

   function automatic logic [31:0] addr_of(input logic [9:0] idx);
      return {20'h00000, idx, 2'h0};
   endfunction : addr_of

   task automatic report_and_stop();
      if (err_total == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         $display("CHECK FAILED %0t register read %h expected %h", $time, got, exp);
         err_total++;
      end
   endtask : chk_reg

   task automatic chk_pin(input logic [11:0] got, input logic [11:0] exp);
      checks_done++;
      if (got !== exp) begin
         $display("CHECK FAILED %0t output %h expected %h", $time, got, exp);
         err_total++;
      end
   endtask : chk_pin

   // called just after a rising edge; returns at the edge that ends the data phase
   task automatic bus_xfer(input logic [31:0] a, input logic wr, input logic [31:0] d,
                           input logic [2:0] sz, output logic [31:0] rd);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= wr;
      hsize  <= sz;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
      chk_pin({11'h000, hresp}, 12'h000);
   endtask : bus_xfer

   task automatic bus_wr(input logic [9:0] idx, input logic [31:0] d);
      bus_xfer(addr_of(idx), 1'b1, d, HSIZE_WORD, rd_val);
   endtask : bus_wr

   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
      bus_xfer(a, 1'b0, 32'h00000000, HSIZE_WORD, rd_val);
      chk_reg(rd_val, exp);
   endtask : rd_chk

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
   endtask : settle

   // the pin levels that every reset must restore
   task automatic chk_rst_pins();
      chk_pin({10'h000, coupling, sync_pd}, 12'h000);
      chk_pin({5'h00, st_a, 2'h0, st_b, st_c}, 12'h012);
      chk_pin({7'h00, sw_code}, 12'h000);
      chk_pin(sw_mv, 12'(SWING_BASE_MV));
      chk_pin({11'h000, drv_off}, 12'h000);
      chk_pin({10'h000, conv1_pd, conv0_pd}, 12'h003);
      chk_pin({11'h000, aclk_off}, 12'h001);
   endtask : chk_rst_pins

   initial begin
      repeat (5000) @(posedge clk);
      err_total++;
      report_and_stop();
   end

   initial begin
      clk = 1'b0; rst = 1'b1; hsel = 1'b0; haddr = 32'h00000000; htrans = 2'h0;
      hwrite = 1'b0; hsize = HSIZE_WORD; hwdata = 32'h00000000;
      err_total = 0; checks_done = 0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      chk_rst_pins();
      rd_chk(addr_of(IDX_SYNC_REF), 32'h00000000);
      rd_chk(addr_of(IDX_STARTUP), 32'h00000012);
      rd_chk(addr_of(IDX_SWING), 32'h00000000);
      rd_chk(addr_of(IDX_DRIVER), 32'h00000000);
      rd_chk(addr_of(IDX_CONV_PD), 32'h00000003);
      rd_chk(addr_of(IDX_ACLK), 32'h00000001);
      // subclass 0 host setting: receiver down, DC coupling
      bus_wr(IDX_SYNC_REF, 32'h00000041);
      settle(1);
      chk_pin({10'h000, coupling, sync_pd}, 12'h003);
      bus_wr(IDX_SYNC_REF, 32'h0000007E);
      rd_chk(addr_of(IDX_SYNC_REF), 32'h0000007E);
      chk_pin({10'h000, coupling, sync_pd}, 12'h002);
      // start-up window opened then closed by the host
      bus_wr(IDX_STARTUP, 32'h000000FE);
      rd_chk(addr_of(IDX_STARTUP), 32'h00000072);
      chk_pin({5'h00, st_a, 2'h0, st_b, st_c}, 12'h072);
      bus_wr(IDX_STARTUP, 32'h00000001);
      settle(1);
      chk_pin({5'h00, st_a, 2'h0, st_b, st_c}, 12'h001);
      // every swing code of both formulas plus the first unused one
      for (int c = 0; c < 21; c++) begin
         bus_wr(IDX_SWING, 32'(c));
         settle(2);
         exp_mv = (c <= 9) ? SWING_BASE_MV - SWING_STEP_MV * c :
                  (c <= 19) ? (SWING_NEG_TOP - c) * SWING_STEP_MV - SWING_NEG_OFS_MV : 0;
         chk_pin({7'h00, sw_code}, 12'(c));
         chk_pin(sw_mv, 12'(exp_mv));
         chk_pin({11'h000, sw_inv}, {11'h000, c >= 10 && c <= 19});
         rd_chk(addr_of(IDX_SWING_STAT), {30'h0, c >= 20, c >= 10 && c <= 19});
      end
      bus_wr(IDX_SWING, 32'h000000E9);
      rd_chk(addr_of(IDX_SWING), 32'h00000009);
      // driver off and back on, reserved bits read zero
      bus_wr(IDX_DRIVER, 32'h000000FF);
      rd_chk(addr_of(IDX_DRIVER), 32'h00000001);
      chk_pin({11'h000, drv_off}, 12'h001);
      bus_wr(IDX_DRIVER, 32'h00000000);
      settle(1);
      chk_pin({11'h000, drv_off}, 12'h000);
      // each converter separately
      for (int v = 0; v < 4; v++) begin
         bus_wr(IDX_CONV_PD, 32'(v) | 32'h000000FC);
         rd_chk(addr_of(IDX_CONV_PD), 32'(v));
         chk_pin({10'h000, conv1_pd, conv0_pd}, 12'(v));
      end
      bus_wr(IDX_ACLK, 32'h000000A4);
      rd_chk(addr_of(IDX_ACLK), 32'h000000A4);
      chk_pin({11'h000, aclk_off}, 12'h000);
      // refused accesses: byte size, misaligned, unmapped, high address
      bus_xfer(addr_of(IDX_ACLK), 1'b1, 32'h00000001, 3'h0, rd_val);
      rd_chk(addr_of(IDX_ACLK), 32'h000000A4);
      bus_xfer(addr_of(IDX_ACLK), 1'b0, 32'h00000000, 3'h0, rd_val);
      chk_reg(rd_val, 32'h00000000);
      rd_chk(addr_of(IDX_ACLK) | 32'h00000001, 32'h00000000);
      rd_chk(addr_of(IDX_ACLK) | 32'h00001000, 32'h00000000);
      bus_wr(10'h100, 32'h0000005A);
      rd_chk(addr_of(10'h100), 32'h00000000);
      // reset in mid-run restores every control level
      rst <= 1'b1;
      settle(1);
      rst <= 1'b0;
      settle(1);
      chk_rst_pins();
      rd_chk(addr_of(IDX_STARTUP), 32'h00000012);
      report_and_stop();
   end
endmodule : scp_regs_tb

// ===== scp_swing_dec.sv
/*
   swing decoder: turns the clock driver swing code into a signed mV level
   and an inversion flag, all registered.
   assumes the code comes from a register on the same clock.
*/
`timescale 1ns/10ps
module scp_swing_dec
   import scp_pkg::*;
(
   // clock and reset
   input  wire logic CLK_I,
   input  wire logic SYS_RST_I,
   // code in, level out
   scp_swing_if.dec  sw
);
   logic signed [11:0] next_swing_mv;
   logic               next_invert;
   logic               next_valid;

   always_comb begin
      next_swing_mv = 12'sh000;
      next_invert   = 1'b0;
      next_valid    = 1'b1;
      if (sw.code <= SWING_LAST_POS) begin
         next_swing_mv = 12'(SWING_BASE_MV - SWING_STEP_MV * int'(sw.code));
      end else if (sw.code <= SWING_LAST_NEG) begin
         // negative level means the output clock is inverted
         next_swing_mv = 12'((SWING_NEG_TOP - int'(sw.code)) * SWING_STEP_MV - SWING_NEG_OFS_MV);
         next_invert   = 1'b1;
      end else begin
         // codes 20..31 have no defined level; report them and drive zero
         next_valid = 1'b0;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         sw.swing_mv   <= 12'(SWING_BASE_MV);
         sw.invert     <= 1'b0;
         sw.code_valid <= 1'b1;
      end else begin
         sw.swing_mv   <= next_swing_mv;
         sw.invert     <= next_invert;
         sw.code_valid <= next_valid;
      end
   end

   AST_SWING_LINEAR: assert property (
      @(posedge CLK_I) disable iff (SYS_RST_I)
      (sw.code <= SWING_LAST_POS) |=>
         (sw.swing_mv == 12'(SWING_BASE_MV - SWING_STEP_MV * int'($past(sw.code))) && !sw.invert)
   ) else $error("swing level wrong for codes 0 to 9");

   AST_SWING_NEGATIVE: assert property (
      @(posedge CLK_I) disable iff (SYS_RST_I)
      (sw.code > SWING_LAST_POS && sw.code <= SWING_LAST_NEG) |=>
         (sw.invert && sw.swing_mv < 0 &&
          sw.swing_mv == 12'((SWING_NEG_TOP - int'($past(sw.code))) * SWING_STEP_MV - SWING_NEG_OFS_MV))
   ) else $error("swing level wrong for codes 10 to 19");
endmodule : scp_swing_dec

// ===== scp_swing_if.sv
/*
   carrier between the register bank and the swing decoder.
   assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface scp_swing_if;
   logic        [4:0]  code;
   logic signed [11:0] swing_mv;
   logic               invert;
   logic               code_valid;

   modport ctl (output code, input swing_mv, input invert, input code_valid);
   modport dec (input code, output swing_mv, output invert, output code_valid);
endinterface : scp_swing_if
